/* File: hdl/ipsf_consts.svh */
/*
 Constants for the exchange-side ISDN port status machine: event and
 output codes. Assumes inclusion by bare name from the design files.
*/
`ifndef IPSF_CONSTS_SVH
`define IPSF_CONSTS_SVH

// ==========================================================
// Input event codes
`define IPSF_EV_W 4
`define IPSF_EV_ACT_REQ 4'h0
`define IPSF_EV_FE102 4'h1
`define IPSF_EV_FE103 4'h2
`define IPSF_EV_FE104 4'h3
`define IPSF_EV_DEACT_REQ 4'h4
`define IPSF_EV_FE106 4'h5
`define IPSF_EV_UNBLOCK_REQ 4'h6
`define IPSF_EV_BLOCK_CMD 4'h7
`define IPSF_EV_FE202 4'h8
`define IPSF_EV_FE204 4'h9
`define IPSF_EV_FE205 4'ha
`define IPSF_EV_FE206 4'hb
`define IPSF_EV_DBLOCK_REQ 4'hc
`define IPSF_EV_DUNBLOCK_REQ 4'hd

// ==========================================================
// Output pulse bit positions
`define IPSF_OUT_W 16
`define IPSF_O_FE101 0
`define IPSF_O_FE105 1
`define IPSF_O_FE201 2
`define IPSF_O_FE203 3
`define IPSF_O_FE207 4
`define IPSF_O_FE208 5
`define IPSF_O_AWI 6
`define IPSF_O_AI 7
`define IPSF_O_PH_AI 8
`define IPSF_O_DI 9
`define IPSF_O_PH_DI 10
`define IPSF_O_UBI 11
`define IPSF_O_UBR 12
`define IPSF_O_BI 13
`define IPSF_O_BR 14
`define IPSF_O_GI 15

`endif

/* File: hdl/ipsf_next.sv */
/*
 Combinational transition table of the port status machine: given the
 current state and one event, gives next state and output pulses.
 Assumes the caller qualifies the result with the event strobe.
*/
`include "ipsf_consts.svh"
`default_nettype none
module ipsf_next (
   input wire ipsf_pkg::ipsf_state_t curState,
   input wire logic [`IPSF_EV_W-1:0] evCode,
   output ipsf_pkg::ipsf_state_t nxtState,
   output logic [`IPSF_OUT_W-1:0] outs,
   output logic unexpected
);
   wire logic isBlk = (curState == ipsf_pkg::ST_BLOCKED);
   wire logic isLu = (curState == ipsf_pkg::ST_LOCAL_UNBLOCK);
   wire logic isRu = (curState == ipsf_pkg::ST_REMOTE_UNBLOCK);
   wire logic isOd = (curState == ipsf_pkg::ST_OPER_DEACT);
   wire logic isAi = (curState == ipsf_pkg::ST_ACT_INIT);
   wire logic isAa = (curState == ipsf_pkg::ST_ACCESS_ACT);
   wire logic isOper = isOd | isAi | isAa;

   always_comb
   begin
      nxtState = curState;
      outs = '0;
      unexpected = 1'b0;
      case (evCode)
         `IPSF_EV_ACT_REQ:
         begin
            if (isOd)
            begin
               outs[`IPSF_O_FE101] = 1'b1;
               nxtState = ipsf_pkg::ST_ACT_INIT;
            end
            else if (!isAi)
               unexpected = 1'b1;
         end
         `IPSF_EV_FE102:
         begin
            if (isLu | isOd)
            begin
               outs[`IPSF_O_AWI] = 1'b1;
               nxtState = ipsf_pkg::ST_ACT_INIT;
            end
            else if (isRu | isAa)
               unexpected = 1'b1;
         end
         `IPSF_EV_FE103:
         begin
            if (isAa)
               unexpected = 1'b1;
         end
         `IPSF_EV_FE104:
         begin
            if (isLu | isOd | isAi)
            begin
               outs[`IPSF_O_AI] = 1'b1;
               outs[`IPSF_O_PH_AI] = 1'b1;
               nxtState = ipsf_pkg::ST_ACCESS_ACT;
            end
            else if (isRu)
               unexpected = 1'b1;
         end
         `IPSF_EV_DEACT_REQ:
         begin
            if (isOper)
               outs[`IPSF_O_FE105] = 1'b1;
            if (isAi)
               outs[`IPSF_O_DI] = 1'b1;
            if (isAa)
               outs[`IPSF_O_PH_DI] = 1'b1;
            if (isAi | isAa)
               nxtState = ipsf_pkg::ST_OPER_DEACT;
         end
         `IPSF_EV_FE106:
         begin
            if (isOper)
               outs[`IPSF_O_DI] = 1'b1;
            if (isAa)
               outs[`IPSF_O_PH_DI] = 1'b1;
            if (isAi | isAa)
               nxtState = ipsf_pkg::ST_OPER_DEACT;
         end
         `IPSF_EV_UNBLOCK_REQ:
         begin
            outs[`IPSF_O_FE201] = 1'b1;
            if (isBlk)
               nxtState = ipsf_pkg::ST_LOCAL_UNBLOCK;
            if (isRu)
            begin
               outs[`IPSF_O_UBI] = 1'b1;
               nxtState = ipsf_pkg::ST_OPER_DEACT;
            end
            if (isAa)
            begin
               outs[`IPSF_O_AI] = 1'b1;
               outs[`IPSF_O_PH_AI] = 1'b1;
            end
         end
         `IPSF_EV_BLOCK_CMD:
         begin
            outs[`IPSF_O_FE203] = 1'b1;
            nxtState = ipsf_pkg::ST_BLOCKED;
         end
         `IPSF_EV_FE202:
         begin
            if (isBlk)
            begin
               outs[`IPSF_O_UBR] = 1'b1;
               nxtState = ipsf_pkg::ST_REMOTE_UNBLOCK;
            end
            else if (isRu)
               outs[`IPSF_O_UBR] = 1'b1;
            else
               outs[`IPSF_O_UBI] = 1'b1;
            if (isLu)
               nxtState = ipsf_pkg::ST_OPER_DEACT;
         end
         `IPSF_EV_FE204:
         begin
            if (!isBlk)
            begin
               outs[`IPSF_O_BI] = 1'b1;
               nxtState = ipsf_pkg::ST_BLOCKED;
            end
            if (isAi | isAa)
            begin
               outs[`IPSF_O_DI] = 1'b1;
               outs[`IPSF_O_PH_DI] = 1'b1;
            end
         end
         `IPSF_EV_FE205:
            outs[`IPSF_O_BR] = isOper;
         `IPSF_EV_FE206:
         begin
            outs[`IPSF_O_GI] = isOper;
            unexpected = !isOper;
         end
         `IPSF_EV_DBLOCK_REQ:
         begin
            outs[`IPSF_O_FE207] = isAa;
            unexpected = !isAa;
         end
         `IPSF_EV_DUNBLOCK_REQ:
         begin
            outs[`IPSF_O_FE208] = isAa;
            unexpected = !isAa;
         end
         default:
            unexpected = 1'b1;
      endcase
   end
endmodule : ipsf_next
`default_nettype wire

/* File: hdl/ipsf_pkg.sv */
/*
 Types for the exchange-side ISDN port status machine.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package ipsf_pkg;
   typedef enum logic [2:0] {
      ST_BLOCKED,
      ST_LOCAL_UNBLOCK,
      ST_REMOTE_UNBLOCK,
      ST_OPER_DEACT,
      ST_ACT_INIT,
      ST_ACCESS_ACT
   } ipsf_state_t;
endpackage : ipsf_pkg
`default_nettype wire

/* File: hdl/ipsf_port_fsm.sv */
/*
 Exchange-side status machine of one ISDN basic-access user port.
 Assumes events arrive encoded with a one-cycle strobe, synchronous to clk.
*/
// Contract
// - Activation request in operational-deactivated sends FE101, goes activation-initiated.
// - FE102 in local-unblock or deactivated reports awake, goes activation-initiated.
// - FE104 in local-unblock, deactivated or initiated signals activated, goes access-activated.
// - Deactivation request in operational states sends FE105; from activation states indicates deactivation, returns.
// - FE106 in operational states indicates deactivation; activation states return to operational-deactivated.
// - Unblock request always sends FE201 with state-dependent moves and indications.
// - Block command always sends FE203 and enters blocked.
// - FE202 gives unblock request or indication, moving toward operational.
// - FE204 outside blocked indicates block, enters blocked, deactivates activation states.
// - D-channel block/unblock sent as FE207/FE208 only when access-activated.
// - Dash entries accept without transition; slash entries are unexpected, no transition.
`include "ipsf_consts.svh"
`default_nettype none
module ipsf_port_fsm (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic evValid,
   input wire logic [`IPSF_EV_W-1:0] evCode,
   output logic [`IPSF_OUT_W-1:0] outPulse,
   output logic unexpectedPulse,
   output logic [2:0] stateCode,
   output logic operational
);
   // ==========================================================
   // Transition table
   ipsf_pkg::ipsf_state_t state_q;
   ipsf_pkg::ipsf_state_t tblState;
   logic [`IPSF_OUT_W-1:0] tblOuts;
   logic tblUnexp;

   ipsf_next u_next (
      .curState(state_q),
      .evCode(evCode),
      .nxtState(tblState),
      .outs(tblOuts),
      .unexpected(tblUnexp)
   );

   wire ipsf_pkg::ipsf_state_t state_d = evValid ? tblState : state_q;
   wire logic [`IPSF_OUT_W-1:0] out_d = evValid ? tblOuts : '0;
   wire logic unexp_d = evValid & tblUnexp;
   wire logic oper_d = (state_d == ipsf_pkg::ST_OPER_DEACT) |
      (state_d == ipsf_pkg::ST_ACT_INIT) | (state_d == ipsf_pkg::ST_ACCESS_ACT);

   // ==========================================================
   // State and output registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q <= ipsf_pkg::ST_BLOCKED;
         outPulse <= '0;
         unexpectedPulse <= 1'b0;
         operational <= 1'b0;
      end
      else if (clkEn)
      begin
         state_q <= state_d;
         outPulse <= out_d;
         unexpectedPulse <= unexp_d;
         operational <= oper_d;
      end
   end

   assign stateCode = state_q;

   // ==========================================================
   // Checks
   property p_act;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_ACT_REQ && state_q == ipsf_pkg::ST_OPER_DEACT
      |=> outPulse[`IPSF_O_FE101] && state_q == ipsf_pkg::ST_ACT_INIT;
   endproperty
   a_act: assert property (p_act) else $error("activation not started");

   property p_fe102;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE102 && state_q == ipsf_pkg::ST_LOCAL_UNBLOCK
      |=> outPulse[`IPSF_O_AWI] && state_q == ipsf_pkg::ST_ACT_INIT;
   endproperty
   a_fe102: assert property (p_fe102) else $error("awake not reported");

   property p_fe104;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE104 && state_q == ipsf_pkg::ST_ACT_INIT
      |=> outPulse[`IPSF_O_AI] && state_q == ipsf_pkg::ST_ACCESS_ACT;
   endproperty
   a_fe104: assert property (p_fe104) else $error("activation not signalled");

   property p_deact;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_DEACT_REQ && state_q == ipsf_pkg::ST_ACCESS_ACT
      |=> outPulse[`IPSF_O_FE105] && outPulse[`IPSF_O_PH_DI]
         && state_q == ipsf_pkg::ST_OPER_DEACT;
   endproperty
   a_deact: assert property (p_deact) else $error("deactivation wrong");

   property p_fe106;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE106 && state_q == ipsf_pkg::ST_OPER_DEACT
      |=> outPulse[`IPSF_O_DI] && state_q == ipsf_pkg::ST_OPER_DEACT;
   endproperty
   a_fe106: assert property (p_fe106) else $error("FE106 handling wrong");

   property p_unblk;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_UNBLOCK_REQ && state_q == ipsf_pkg::ST_REMOTE_UNBLOCK
      |=> outPulse[`IPSF_O_FE201] && outPulse[`IPSF_O_UBI] && operational;
   endproperty
   a_unblk: assert property (p_unblk) else $error("unblock wrong");

   property p_blk;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_BLOCK_CMD
      |=> outPulse[`IPSF_O_FE203] && state_q == ipsf_pkg::ST_BLOCKED && !operational;
   endproperty
   a_blk: assert property (p_blk) else $error("block wrong");

   property p_fe204;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE204 && state_q == ipsf_pkg::ST_ACT_INIT
      |=> outPulse[`IPSF_O_BI] && outPulse[`IPSF_O_DI] && state_q == ipsf_pkg::ST_BLOCKED;
   endproperty
   a_fe204: assert property (p_fe204) else $error("remote block wrong");

   property p_dch;
      @(posedge clk) disable iff (sys_rst)
      clkEn && !(state_q == ipsf_pkg::ST_ACCESS_ACT)
      |=> !outPulse[`IPSF_O_FE207] && !outPulse[`IPSF_O_FE208];
   endproperty
   a_dch: assert property (p_dch) else $error("D-channel element outside activated");

   property p_pulse;
      @(posedge clk) disable iff (sys_rst)
      clkEn && !evValid |=> outPulse == '0 && !unexpectedPulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("output without event");

   property p_act_aa;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_ACT_REQ && state_q == ipsf_pkg::ST_ACCESS_ACT
      |=> unexpectedPulse && !outPulse[`IPSF_O_FE101] && state_q == ipsf_pkg::ST_ACCESS_ACT;
   endproperty
   a_act_aa: assert property (p_act_aa) else $error("activation accepted when active");

   property p_deact_ai;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_DEACT_REQ && state_q == ipsf_pkg::ST_ACT_INIT
      |=> outPulse[`IPSF_O_FE105] && outPulse[`IPSF_O_DI] && !outPulse[`IPSF_O_PH_DI]
         && state_q == ipsf_pkg::ST_OPER_DEACT;
   endproperty
   a_deact_ai: assert property (p_deact_ai) else $error("deactivation from initiated wrong");

   property p_ubr_aa;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_UNBLOCK_REQ && state_q == ipsf_pkg::ST_ACCESS_ACT
      |=> outPulse[`IPSF_O_FE201] && outPulse[`IPSF_O_AI] && outPulse[`IPSF_O_PH_AI]
         && state_q == ipsf_pkg::ST_ACCESS_ACT;
   endproperty
   a_ubr_aa: assert property (p_ubr_aa) else $error("unblock when active wrong");

   property p_fe202_blk;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE202 && state_q == ipsf_pkg::ST_BLOCKED
      |=> outPulse[`IPSF_O_UBR] && state_q == ipsf_pkg::ST_REMOTE_UNBLOCK;
   endproperty
   a_fe202_blk: assert property (p_fe202_blk) else $error("remote unblock not requested");

   property p_fe202_lu;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE202 && state_q == ipsf_pkg::ST_LOCAL_UNBLOCK
      |=> outPulse[`IPSF_O_UBI] && state_q == ipsf_pkg::ST_OPER_DEACT && operational;
   endproperty
   a_fe202_lu: assert property (p_fe202_lu) else $error("unblock not completed");

   property p_fe205_op;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE205 && operational
      |=> outPulse[`IPSF_O_BR] && state_q == $past(state_q);
   endproperty
   a_fe205_op: assert property (p_fe205_op) else $error("block request not passed");

   property p_fe205_idle;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE205 && !operational
      |=> !outPulse[`IPSF_O_BR] && !unexpectedPulse;
   endproperty
   a_fe205_idle: assert property (p_fe205_idle) else $error("block request not ignored");

   property p_fe206_op;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE206 && operational
      |=> outPulse[`IPSF_O_GI] && !unexpectedPulse;
   endproperty
   a_fe206_op: assert property (p_fe206_op) else $error("grading not forwarded");

   property p_fe206_idle;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_FE206 && !operational
      |=> !outPulse[`IPSF_O_GI] && unexpectedPulse;
   endproperty
   a_fe206_idle: assert property (p_fe206_idle) else $error("grading not refused");

   property p_dblock;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode == `IPSF_EV_DBLOCK_REQ && state_q == ipsf_pkg::ST_ACCESS_ACT
      |=> outPulse[`IPSF_O_FE207] && state_q == ipsf_pkg::ST_ACCESS_ACT;
   endproperty
   a_dblock: assert property (p_dblock) else $error("D-channel block not sent");

   property p_bad_code;
      @(posedge clk) disable iff (sys_rst)
      clkEn && evValid && evCode >= 4'he
      |=> unexpectedPulse && outPulse == '0 && state_q == $past(state_q);
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("unknown code not refused");

   property p_freeze;
      @(posedge clk) disable iff (sys_rst)
      !clkEn |=> $stable(state_q) && $stable(outPulse) && $stable(unexpectedPulse);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule : ipsf_port_fsm
`default_nettype wire

/* File: testbench/ipsf_an_model.sv */
/*
 Far-side port machine model facing the exchange-side port FSM.
 Assumes the bench merges its events into the FSM's event input.
*/
`include "ipsf_consts.svh"
`default_nettype none
module ipsf_an_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`IPSF_OUT_W-1:0] feIn,
   input wire logic cmdValid,
   input wire logic [2:0] cmdSel,
   output logic anValid,
   output logic [`IPSF_EV_W-1:0] anCode,
   output logic dBlocked
);
   timeunit 1ns;
   timeprecision 1ps;
   // Activation supervision span and grading gap, both scaled down for simulation
   localparam logic [7:0] T1_CYCLES = 8'h10;
   localparam logic [7:0] GRADE_GAP = 8'hff;
   logic [2:0] st_q;
   logic [7:0] t1Cnt_q;
   logic [7:0] gradeGap_q;
   wire logic t1Expired = (st_q == 3'h4) && (t1Cnt_q == T1_CYCLES);
   wire logic gradeGo = cmdValid && (cmdSel == 3'h4) && (st_q >= 3'h3) && (gradeGap_q == 8'h00);
   // ==========================================================
   // Activation timer, grading gap and D-channel blocking
   always_ff @(posedge clk)
   begin
      if (sys_rst || st_q != 3'h4)
         t1Cnt_q <= 8'h00;
      else
         t1Cnt_q <= t1Cnt_q + 8'h01;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         gradeGap_q <= 8'h00;
      else if (gradeGo)
         gradeGap_q <= GRADE_GAP;
      else if (gradeGap_q != 8'h00)
         gradeGap_q <= gradeGap_q - 8'h01;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst || st_q != 3'h5)
         dBlocked <= 1'b0;
      else if (feIn[`IPSF_O_FE207])
         dBlocked <= 1'b1;
      else if (feIn[`IPSF_O_FE208])
         dBlocked <= 1'b0;
   end
   // ==========================================================
   // Far-side state table
   always_ff @(posedge clk)
   begin
      anValid <= 1'b0;
      if (sys_rst)
      begin
         st_q <= 3'h0;
         anCode <= 4'h0;
      end
      else if (feIn[`IPSF_O_FE105] && st_q >= 3'h3)
      begin
         anValid <= 1'b1;
         anCode <= `IPSF_EV_FE106;
         st_q <= 3'h3;
      end
      else if (feIn[`IPSF_O_FE203])
         st_q <= 3'h0;
      else if (t1Expired)
      begin
         anValid <= 1'b1;
         anCode <= `IPSF_EV_FE106;
         st_q <= 3'h3;
      end
      else if (feIn[`IPSF_O_FE201] && st_q <= 3'h1)
         st_q <= (st_q == 3'h0) ? 3'h2 : 3'h3;
      else if (feIn[`IPSF_O_FE101] && st_q == 3'h3)
         st_q <= 3'h4;
      else if (cmdValid && cmdSel == 3'h0)
      begin
         anValid <= 1'b1;
         anCode <= `IPSF_EV_FE202;
         st_q <= (st_q == 3'h0) ? 3'h1 : ((st_q == 3'h2) ? 3'h3 : st_q);
      end
      else if (cmdValid && cmdSel == 3'h1)
      begin
         anValid <= 1'b1;
         anCode <= `IPSF_EV_FE204;
         st_q <= 3'h0;
      end
      else if (cmdValid && cmdSel == 3'h2 && st_q >= 3'h3)
      begin
         anValid <= 1'b1;
         anCode <= `IPSF_EV_FE205;
      end
      else if (cmdValid && cmdSel == 3'h3 && st_q == 3'h4)
      begin
         anValid <= 1'b1;
         anCode <= `IPSF_EV_FE104;
         st_q <= 3'h5;
      end
      else if (gradeGo)
      begin
         anValid <= 1'b1;
         anCode <= `IPSF_EV_FE206;
      end
      else if (cmdValid && cmdSel == 3'h5)
      begin
         anValid <= 1'b1;
         anCode <= `IPSF_EV_FE204;
         st_q <= 3'h0;
      end
      else
         st_q <= st_q;
   end
endmodule : ipsf_an_model
`default_nettype wire

/* File: testbench/test_ipsf_port_fsm.sv */
/*
 Self-checking bench of the exchange-side port FSM with a far-side model.
 Assumes the design and model files are compiled before this one.
*/
`include "ipsf_consts.svh"
`default_nettype none
module test_ipsf_port_fsm;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clkEn = 1'b1;
   logic tbValid = 1'b0;
   logic [`IPSF_EV_W-1:0] tbCode = 4'h0;
   logic cmdValid = 1'b0;
   logic [2:0] cmdSel = 3'h0;
   logic anValid;
   logic [`IPSF_EV_W-1:0] anCode;
   logic [`IPSF_OUT_W-1:0] outPulse;
   logic unexpectedPulse;
   logic [2:0] stateCode;
   logic operational;
   logic dBlocked;
   int err_count = 0;
   int checks_done = 0;
   wire logic evValid = tbValid | anValid;
   wire logic [`IPSF_EV_W-1:0] evCode = anValid ? anCode : tbCode;
   always #2 clk = ~clk;
   ipsf_port_fsm dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .evValid(evValid),
      .evCode(evCode), .outPulse(outPulse), .unexpectedPulse(unexpectedPulse),
      .stateCode(stateCode), .operational(operational));
   ipsf_an_model peer (.clk(clk), .sys_rst(sys_rst), .feIn(outPulse), .cmdValid(cmdValid),
      .cmdSel(cmdSel), .anValid(anValid), .anCode(anCode), .dBlocked(dBlocked));
   // ==========================================================
   // Shared helpers
   function automatic logic [15:0] m(input int i);
      return 16'h0001 << i;
   endfunction : m
   task automatic chk(input logic [20:0] g, input logic [20:0] e);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk
   task automatic cmp(input logic [20:0] e);
      chk({operational, unexpectedPulse, stateCode, outPulse}, e);
   endtask : cmp
   // Mode 0 bench event, 1 far-side command, 2 wait for a far-side reply
   task automatic step(input int mode, input logic [3:0] c, input logic [15:0] p,
      input logic u, input logic [2:0] s);
      int n;
      @(posedge clk);
      if (mode == 1)
      begin
         cmdValid <= 1'b1;
         cmdSel <= c[2:0];
      end
      else if (mode == 0)
      begin
         tbValid <= 1'b1;
         tbCode <= c;
      end
      @(posedge clk);
      cmdValid <= 1'b0;
      tbValid <= 1'b0;
      #1;
      for (n = 0; mode != 0 && n < 32 && outPulse === 16'h0; n++)
      begin
         @(posedge clk);
         #1;
      end
      cmp({s >= 3'h3, u, s, p});
   endtask : step
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // ==========================================================
   // Scenarios
   task automatic s_unblock();
      step(0, `IPSF_EV_UNBLOCK_REQ, m(`IPSF_O_FE201), 1'b0, 3'h1);
      step(1, 4'h0, m(`IPSF_O_UBI), 1'b0, 3'h3);
   endtask : s_unblock
   task automatic s_activate();
      step(0, `IPSF_EV_ACT_REQ, m(`IPSF_O_FE101), 1'b0, 3'h4);
      step(1, 4'h3, m(`IPSF_O_AI) | m(`IPSF_O_PH_AI), 1'b0, 3'h5);
   endtask : s_activate
   task automatic s_access();
      step(0, `IPSF_EV_DBLOCK_REQ, m(`IPSF_O_FE207), 1'b0, 3'h5);
      step(0, `IPSF_EV_DUNBLOCK_REQ, m(`IPSF_O_FE208), 1'b0, 3'h5);
      step(0, `IPSF_EV_ACT_REQ, 16'h0, 1'b1, 3'h5);
      step(0, `IPSF_EV_FE104, 16'h0, 1'b0, 3'h5);
      step(0, `IPSF_EV_FE103, 16'h0, 1'b1, 3'h5);
      step(0, `IPSF_EV_FE206, m(`IPSF_O_GI), 1'b0, 3'h5);
      step(1, 4'h4, m(`IPSF_O_GI), 1'b0, 3'h5);
      step(1, 4'h4, 16'h0, 1'b0, 3'h5);
      step(0, `IPSF_EV_UNBLOCK_REQ, m(`IPSF_O_FE201) | m(`IPSF_O_AI) | m(`IPSF_O_PH_AI),
         1'b0, 3'h5);
      step(0, `IPSF_EV_DBLOCK_REQ, m(`IPSF_O_FE207), 1'b0, 3'h5);
   endtask : s_access
   task automatic s_deact();
      step(0, `IPSF_EV_DEACT_REQ, m(`IPSF_O_FE105) | m(`IPSF_O_PH_DI), 1'b0, 3'h3);
      chk({20'h0, dBlocked}, 21'h1);
      step(2, 4'h0, m(`IPSF_O_DI), 1'b0, 3'h3);
      chk({20'h0, dBlocked}, 21'h0);
      step(0, `IPSF_EV_FE102, m(`IPSF_O_AWI), 1'b0, 3'h4);
      step(0, `IPSF_EV_FE102, 16'h0, 1'b0, 3'h4);
      step(0, `IPSF_EV_FE106, m(`IPSF_O_DI), 1'b0, 3'h3);
      step(0, `IPSF_EV_ACT_REQ, m(`IPSF_O_FE101), 1'b0, 3'h4);
      step(0, `IPSF_EV_DEACT_REQ, m(`IPSF_O_FE105) | m(`IPSF_O_DI), 1'b0, 3'h3);
      step(2, 4'h0, m(`IPSF_O_DI), 1'b0, 3'h3);
      step(1, 4'h2, m(`IPSF_O_BR), 1'b0, 3'h3);
   endtask : s_deact
   task automatic s_t1();
      step(0, `IPSF_EV_ACT_REQ, m(`IPSF_O_FE101), 1'b0, 3'h4);
      step(2, 4'h0, m(`IPSF_O_DI), 1'b0, 3'h3);
   endtask : s_t1
   task automatic s_remote_block();
      step(0, `IPSF_EV_ACT_REQ, m(`IPSF_O_FE101), 1'b0, 3'h4);
      step(1, 4'h1, m(`IPSF_O_BI) | m(`IPSF_O_DI) | m(`IPSF_O_PH_DI), 1'b0, 3'h0);
      step(0, `IPSF_EV_FE205, 16'h0, 1'b0, 3'h0);
      step(0, `IPSF_EV_FE206, 16'h0, 1'b1, 3'h0);
      step(0, `IPSF_EV_FE204, 16'h0, 1'b0, 3'h0);
   endtask : s_remote_block
   task automatic s_remote_unblock();
      step(1, 4'h0, m(`IPSF_O_UBR), 1'b0, 3'h2);
      step(0, `IPSF_EV_FE202, m(`IPSF_O_UBR), 1'b0, 3'h2);
      step(0, `IPSF_EV_UNBLOCK_REQ, m(`IPSF_O_FE201) | m(`IPSF_O_UBI), 1'b0, 3'h3);
      step(0, `IPSF_EV_FE202, m(`IPSF_O_UBI), 1'b0, 3'h3);
      step(1, 4'h5, m(`IPSF_O_BI), 1'b0, 3'h0);
   endtask : s_remote_unblock
   task automatic s_b2b();
      @(posedge clk);
      tbValid <= 1'b1;
      tbCode <= `IPSF_EV_BLOCK_CMD;
      @(posedge clk);
      tbCode <= `IPSF_EV_UNBLOCK_REQ;
      #1;
      cmp({2'b00, 3'h0, m(`IPSF_O_FE203)});
      @(posedge clk);
      tbValid <= 1'b0;
      #1;
      cmp({2'b00, 3'h1, m(`IPSF_O_FE201)});
      step(0, `IPSF_EV_FE102, m(`IPSF_O_AWI), 1'b0, 3'h4);
   endtask : s_b2b
   task automatic s_blocked();
      step(0, `IPSF_EV_BLOCK_CMD, m(`IPSF_O_FE203), 1'b0, 3'h0);
      step(0, `IPSF_EV_BLOCK_CMD, m(`IPSF_O_FE203), 1'b0, 3'h0);
      step(0, `IPSF_EV_DBLOCK_REQ, 16'h0, 1'b1, 3'h0);
      step(0, 4'he, 16'h0, 1'b1, 3'h0);
      @(posedge clk);
      clkEn <= 1'b0;
      tbValid <= 1'b1;
      tbCode <= `IPSF_EV_UNBLOCK_REQ;
      @(posedge clk);
      clkEn <= 1'b1;
      tbValid <= 1'b0;
      #1;
      cmp({2'b00, 3'h0, 16'h0});
   endtask : s_blocked
   // ==========================================================
   // Main sequence and watchdog
   initial
   begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      s_unblock();
      s_activate();
      s_access();
      s_deact();
      s_t1();
      s_remote_block();
      s_remote_unblock();
      s_b2b();
      s_blocked();
      end_of_test();
   end
   initial
   begin
      #20000;
      err_count++;
      end_of_test();
   end
endmodule : test_ipsf_port_fsm
`default_nettype wire
